// >>> lmx_exec.sv
// Executor for the bank-select literal load, working-register literal
// load and working-to-file copy instructions.
// Assumes the fetch stage holds instr_i stable through the decode phase
// of each four-phase cycle and that data memory takes one write strobe
// per cycle, landing it on the edge that ends the write phase.
// Other words write no register or memory but raise illegal_o and still reload mem_addr_o and mem_wdata_o; the index
// pointer of the extended set is modelled by the index_base_i input.
module lmx_exec
  import lmx_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] instr_i,
  input  wire logic        ext_set_en_i,
  input  wire logic [11:0] index_base_i,
  output logic       [1:0] phase_o,
  output logic             cycle_end_o,
  output logic       [7:0] working_o,
  output logic       [7:0] bank_select_o,
  output logic      [11:0] mem_addr_o,
  output logic       [7:0] mem_wdata_o,
  output logic             mem_we_o,
  output logic             status_we_o,
  output logic             illegal_o
);

  // Instruction class decoded in the first phase
  typedef enum logic [1:0] {
    LMX_OP_NONE,
    LMX_OP_BANK,
    LMX_OP_WORK,
    LMX_OP_COPY
  } lmx_op_e;

  // Sorts a program word into one of the three classes or none; the bank load
  // takes any upper literal nibble, since that nibble is dropped anyway
  function automatic lmx_op_e lmx_decode(input logic [15:0] w);
    lmx_op_e o;
    o = LMX_OP_NONE;
    if (w[15:8] == OPC_LOAD_WORKING) begin
      o = LMX_OP_WORK;
    end else if (w[15:8] == OPC_LOAD_BANK_HI) begin
      o = LMX_OP_BANK;
    end else if (w[15:9] == OPC_COPY_WORKING) begin
      o = LMX_OP_COPY;
    end
    return o;
  endfunction : lmx_decode

  // Registered state, one _q and _d pair per group of state
  lmx_phase_e  phase_q, phase_d;
  lmx_op_e     op_q, op_d;
  logic [7:0]  lit_q, lit_d;
  logic        acc_q, acc_d;
  logic [11:0] addr_q, addr_d;
  logic [7:0]  working_q, working_d;
  logic [7:0]  bank_q, bank_d;
  logic [7:0]  wdata_q, wdata_d;
  logic        we_q, we_d;
  logic        ill_q, ill_d;

  // Forms the data memory address of a copy. The indexed test comes
  // before the access bank split, so it shadows the low access half
  function automatic logic [11:0] lmx_resolve(
    input logic        acc,
    input logic [7:0]  f,
    input logic [7:0]  bank,
    input logic        ext,
    input logic [11:0] base
  );
    logic [11:0] r;
    r = 12'h000;
    if (acc) begin
      r = {bank[3:0], f};
    end else if (ext && (f <= INDEXED_MAX)) begin
      r = base + {4'h0, f};
    end else if (f < ACCESS_SPLIT) begin
      r = {ACCESS_LO_BANK, f};
    end else begin
      r = {ACCESS_HI_BANK, f};
    end
    return r;
  endfunction : lmx_resolve

  // Phase sequencer: four edges make one instruction cycle, and each of
  // the three instructions here completes within a single cycle
  always_comb begin
    case (phase_q)
      LMX_DECODE:  phase_d = LMX_READ;
      LMX_READ:    phase_d = LMX_PROCESS;
      LMX_PROCESS: phase_d = LMX_WRITE;
      LMX_WRITE:   phase_d = LMX_DECODE;
      default:     phase_d = LMX_DECODE;
    endcase
  end

  // Phase register; reset lands on a decode phase
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      phase_q <= LMX_DECODE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // Decode: the word is looked at only on the edge that ends the decode
  // phase, so the fetch side is free to change it in the other three
  always_comb begin
    op_d  = op_q;
    lit_d = lit_q;
    acc_d = acc_q;
    ill_d = ill_q;
    if (phase_q == LMX_DECODE) begin
      op_d  = lmx_decode(instr_i);
      lit_d = instr_i[7:0];
      acc_d = instr_i[ACCESS_BIT_POS];
      ill_d = (op_d == LMX_OP_NONE); // Unknown words run as a no-op
    end
  end

  // Decoded class, literal or file address, access bit, illegal flag
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      op_q  <= LMX_OP_NONE;
      lit_q <= 8'h00;
      acc_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      op_q  <= op_d;
      lit_q <= lit_d;
      acc_q <= acc_d;
      ill_q <= ill_d;
    end
  end

  // Address: formed on the edge that ends the read phase, after decode,
  // so a bank load in the instruction just before already counts; the
  // extended set enable is sampled here and nowhere else
  always_comb begin
    addr_d = addr_q;
    if (phase_q == LMX_READ) begin
      addr_d = lmx_resolve(acc_q, lit_q, bank_q, ext_set_en_i,
                           index_base_i);
    end
  end

  // Resolved address; stands from the process phase to the next read
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      addr_q <= 12'h000;
    end else begin
      addr_q <= addr_d;
    end
  end

  // Write data and strobe: captured on the edge that ends the process
  // phase, so both stand through the whole write phase
  always_comb begin
    wdata_d = wdata_q;
    we_d    = 1'b0;
    if (phase_q == LMX_PROCESS) begin
      wdata_d = working_q;
      we_d    = (op_q == LMX_OP_COPY);
    end
  end

  // Strobe register; a one-cycle pulse per copy
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wdata_q <= 8'h00;
      we_q    <= 1'b0;
    end else begin
      wdata_q <= wdata_d;
      we_q    <= we_d;
    end
  end

  // Working and bank select: written on the edge that ends the write
  // phase, so a copy in the same cycle still sees the old working value
  always_comb begin
    working_d = working_q;
    bank_d    = bank_q;
    if (phase_q == LMX_WRITE) begin
      case (op_q)
        LMX_OP_BANK: bank_d    = {BANK_HI_FIXED, lit_q[3:0]};
        LMX_OP_WORK: working_d = lit_q;
        default: ;
      endcase
    end
  end

  // Architectural registers
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      working_q <= WORKING_RST;
      bank_q    <= BANK_RST;
    end else begin
      working_q <= working_d;
      bank_q    <= bank_d;
    end
  end

  // Outputs; none of these instructions touches the status flags, so
  // their write enable is tied low rather than decoded
  assign phase_o       = phase_q;
  assign cycle_end_o   = (phase_q == LMX_WRITE);
  assign working_o     = working_q;
  assign bank_select_o = bank_q;
  assign mem_addr_o    = addr_q;
  assign mem_wdata_o   = wdata_q;
  assign mem_we_o      = we_q;
  assign status_we_o   = 1'b0;
  assign illegal_o     = ill_q;

endmodule : lmx_exec

// >>> lmx_pkg.sv
// Package for the literal and move instruction executor.
// Assumes a single core clock; shared by the executor and its checker.
package lmx_pkg;

  // Opcode patterns in the upper bits of the 16-bit program word
  localparam logic [7:0] OPC_LOAD_BANK_HI    = 8'h01; // 0000 0001
  localparam logic [7:0] OPC_LOAD_WORKING    = 8'h0E; // 0000 1110
  localparam logic [6:0] OPC_COPY_WORKING    = 7'h37; // 0110 111

  // Field positions in the program word
  localparam int ACCESS_BIT_POS = 8;

  // Reset values and the fixed upper bank nibble
  localparam logic [7:0] WORKING_RST = 8'h00;
  localparam logic [7:0] BANK_RST    = 8'h00;
  localparam logic [3:0] BANK_HI_FIXED = 4'h0;

  // Access bank split and indexed literal offset limit
  localparam logic [7:0] ACCESS_SPLIT    = 8'h60;
  localparam logic [7:0] INDEXED_MAX     = 8'h5F; // 95
  localparam logic [3:0] ACCESS_HI_BANK  = 4'hF;
  localparam logic [3:0] ACCESS_LO_BANK  = 4'h0;

  // Four phases of one instruction cycle
  typedef enum logic [1:0] {
    LMX_DECODE,
    LMX_READ,
    LMX_PROCESS,
    LMX_WRITE
  } lmx_phase_e;

endpackage : lmx_pkg

// >>> lmx_exec_checker.sv
// Port assertions for lmx_exec.
// Bound to each lmx_exec; one clock, sync reset.
module lmx_exec_checker
  import lmx_pkg::*;
(
  input logic        ref_clk_i,
  input logic        sys_rst_i,
  input logic [15:0] instr_i,
  input logic        ext_set_en_i,
  input logic [11:0] index_base_i,
  input logic [1:0]  phase_o,
  input logic        cycle_end_o,
  input logic [7:0]  working_o,
  input logic [7:0]  bank_select_o,
  input logic [11:0] mem_addr_o,
  input logic [7:0]  mem_wdata_o,
  input logic        mem_we_o,
  input logic        status_we_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Take edge: a decode phase outside reset; later steps count from it
  sequence s_take;
    !sys_rst_i && phase_o == 2'h0;
  endsequence
  // Take edge of a copy
  sequence s_copy;
    s_take ##0 instr_i[15:9] == OPC_COPY_WORKING;
  endsequence
  a_bank_load:
    assert property (s_take ##0 instr_i[15:8] == OPC_LOAD_BANK_HI |->
      ##4 bank_select_o == {BANK_HI_FIXED, $past(instr_i[3:0], 4)})
      else $error("bsel");
  a_work_load:
    assert property (s_take ##0 instr_i[15:8] == OPC_LOAD_WORKING
      |-> ##4 working_o == $past(instr_i[7:0], 4)) else $error("work");
  a_copy_write:
    assert property (s_copy |-> ##3 mem_we_o && mem_wdata_o == working_o)
      else $error("copy");
  a_addr_bank:
    assert property (s_copy ##0 instr_i[8] |->
      ##2 mem_addr_o == {bank_select_o[3:0], $past(instr_i[7:0], 2)})
      else $error("addr");
  a_addr_access:
    assert property (s_copy ##0 !instr_i[8] && instr_i[7:0] >= ACCESS_SPLIT
      |-> ##2 mem_addr_o == {ACCESS_HI_BANK, $past(instr_i[7:0], 2)})
      else $error("acc");
  a_addr_low:
    assert property (s_copy ##0 !instr_i[8] && instr_i[7:0] < ACCESS_SPLIT
      ##1 !ext_set_en_i
      |-> ##1 mem_addr_o == {ACCESS_LO_BANK, $past(instr_i[7:0], 2)})
      else $error("acc low");
  a_addr_index:
    assert property (s_copy ##0 !instr_i[8] && instr_i[7:0] <= INDEXED_MAX
      ##1 ext_set_en_i
      |-> ##1 mem_addr_o == index_base_i + {4'h0, $past(instr_i[7:0], 2)})
      else $error("indexed");
  a_phase_step:
    assert property (!sys_rst_i |=> phase_o == $past(phase_o) + 2'h1)
      else $error("phase");
  a_flags_quiet: assert property (!status_we_o) else $error("flags");
  a_we_cause:
    assert property (mem_we_o |-> cycle_end_o
      && $past(instr_i[15:9], 3) == OPC_COPY_WORKING) else $error("we");
endmodule : lmx_exec_checker

bind lmx_exec lmx_exec_checker lmx_exec_checker_i (.*);

// >>> lmx_mem_model.sv
// Data memory behind the executor.
// Assumes one write strobe per instruction cycle.
module lmx_mem_model (
  input wire logic        ref_clk_i,
  input wire logic        mem_we_i,
  input wire logic [11:0] mem_addr_i,
  input wire logic [7:0]  mem_wdata_i
);
  logic [7:0] ram [4096];
  // Any byte may be hit; bench peeks here after the write edge
  always_ff @(posedge ref_clk_i) begin
    if (mem_we_i) ram[mem_addr_i] <= mem_wdata_i;
  end
endmodule : lmx_mem_model

// >>> lmx_exec_tb.sv
// Self-checking bench for lmx_exec with a data memory model.
// Assumes package, executor, model and checker compile first.
module lmx_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i, sys_rst_i, ext_set_en_i, mem_we_o;
  logic        cycle_end_o, status_we_o, illegal_o;
  logic [1:0]  phase_o;
  logic [7:0]  working_o, bank_select_o, mem_wdata_o;
  logic [11:0] index_base_i, mem_addr_o;
  logic [15:0] instr_i;
  int          fails = 0;
  int          n_compared = 0;
`define CHK(nm, ex, sn) begin n_compared++; if ((sn) !== (ex)) begin \
  fails++; $display("MISMATCH %s exp %0h got %0h", nm, ex, sn); end end
  lmx_exec lmx_exec_i (.*);
  lmx_mem_model lmx_mem_model_i (.ref_clk_i, .mem_we_i(mem_we_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o));
  // Core clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Word set at the edge ending phase 3; returns mid next phase 3.
  // Phase is read only at falling edges, where it has settled
  task automatic exec(input logic [15:0] w, input logic e);
    while (phase_o !== 2'h3) @(negedge ref_clk_i);
    @(posedge ref_clk_i);
    instr_i <= w;
    ext_set_en_i <= e;
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask : exec
  task automatic t_loads;
    exec(16'h0E5A, 1'b0);
    exec(16'h010F, 1'b0);
    `CHK("work", 8'h5A, working_o)
    `CHK("flags", 1'b0, status_we_o)
  endtask : t_loads
  // Bank, access bank both halves, indexed edge 5F/60, top byte
  task automatic t_copy;
    logic [28:0] row [6] = '{{1'b0, 16'h6F80, 12'hF80},
      {1'b0, 16'h6E20, 12'h020}, {1'b0, 16'h6EA0, 12'hFA0},
      {1'b1, 16'h6E5F, 12'h25F}, {1'b1, 16'h6E60, 12'hF60},
      {1'b1, 16'h6FFF, 12'hFFF}};
    foreach (row[i]) begin
      exec(row[i][27:12], row[i][28]);
      `CHK("bank", 8'h0F, bank_select_o)
      `CHK("we", 1'b1, mem_we_o & cycle_end_o)
      `CHK("wdata", 8'h5A, mem_wdata_o)
      `CHK("addr", row[i][11:0], mem_addr_o)
    end
  endtask : t_copy
  task automatic t_illegal;
    exec(16'hFFFF, 1'b0);
    `CHK("illegal", 1'b1, illegal_o)
    `CHK("quiet", 1'b0, mem_we_o)
    `CHK("ram", 8'h5A, lmx_mem_model_i.ram[12'hFFF])
  endtask : t_illegal
  // Mid-run reset clears state; then a bank load with upper nibble set
  task automatic t_reset;
    exec(16'h0E33, 1'b0);
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    instr_i <= 16'hFFFF;
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(negedge ref_clk_i);
    `CHK("rst phase", 2'h0, phase_o)
    `CHK("rst work", 8'h00, working_o)
    `CHK("rst bank", 8'h00, bank_select_o)
    exec(16'h01A3, 1'b0);
    exec(16'h6E10, 1'b0);
    `CHK("bank hi", 8'h03, bank_select_o)
    `CHK("wdata rst", 8'h00, mem_wdata_o)
    `CHK("addr low", 12'h010, mem_addr_o)
  endtask : t_reset
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // Reset for 4 cycles, then the scenarios
  initial begin
    sys_rst_i = 1'b1;
    instr_i = 16'hFFFF;
    ext_set_en_i = 1'b0;
    index_base_i = 12'h200;
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(negedge ref_clk_i);
    t_loads();
    t_copy();
    t_illegal();
    t_reset();
    wrap_up();
  end
  // Twelve instructions and two resets need under 1 us; far past that
  // means a hang
  initial begin
    #5000;
    fails++;
    wrap_up();
  end
endmodule : lmx_exec_tb
